// >>> logic/upfc_pkg.sv
// package for the upstream port failover control block
package upfc_pkg;
    // register byte offsets
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_SWITCH_CONTROL_REG  = 4'h8;
    // control register fields
    localparam int CTRL_SEL_BIT    = 0;
    localparam int CTRL_SIGNAL_FAILOVER_ENABLE_BIT = 1;
    // status register fields
    localparam int STS_EN_BIT      = 0;
    localparam int STS_CURRENT_UPSTREAM_PORT_BIT    = 1;
    localparam int STS_CHG_BIT     = 2;
    localparam int STS_CHGI_BIT    = 3;
    // switch control fields
    localparam int SWITCH_CONTROL_REG_DLDHR_BIT = 0;
    // boot switch mode encodings
    localparam logic [3:0] MODE_NORMAL       = 4'h0;
    localparam logic [3:0] MODE_NORMAL_EE    = 4'h1;
    localparam logic [3:0] MODE_FO_P0        = 4'h2;
    localparam logic [3:0] MODE_FO_P2        = 4'h3;
    localparam logic [3:0] MODE_EE_FO_P0     = 4'h4;
    localparam logic [3:0] MODE_EE_FO_P2     = 4'h5;
    // timing: detect hold time before mux flip, in ns and in clock cycles
    localparam int DETECT_NS    = 64;
    localparam int CLK_NS       = 8;
    localparam int DETECT_CYC   = (DETECT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] RESET_CTRL = 8'h00;

    typedef enum logic [2:0] {
        UPFC_IDLE   = 3'b000,
        UPFC_DOWN   = 3'b001,
        UPFC_SWITCH = 3'b010,
        UPFC_TRAIN  = 3'b011
    } upfc_state_e;

    // request sources
    typedef struct packed {
        logic sw;
        logic pin;
    } upfc_req_s;

    // link-side control bundle
    typedef struct packed {
        logic force_detect;
        logic dl_down;
        logic flush;
        logic start_train;
    } upfc_link_s;
endpackage

// >>> logic/upfc_mode_dec.sv
// boot switch mode decoder
`timescale 1ns/1ns
module upfc_mode_dec (
    // mode in
    input  wire logic [3:0] mode_i,
    // decoded
    output logic            fo_mode_o,
    output logic            init_p2_o
);
    always_comb begin
        fo_mode_o = 1'b0;
        init_p2_o = 1'b0;
        case (mode_i)
            upfc_pkg::MODE_FO_P0,
            upfc_pkg::MODE_EE_FO_P0: begin
                fo_mode_o = 1'b1;
            end
            upfc_pkg::MODE_FO_P2,
            upfc_pkg::MODE_EE_FO_P2: begin
                fo_mode_o = 1'b1;
                init_p2_o = 1'b1;
            end
            default: begin
                fo_mode_o = 1'b0;
                init_p2_o = 1'b0;
            end
        endcase
    end
endmodule

// >>> logic/upfc_detect_timer.sv
// down-counter that times the detect hold period
`timescale 1ns/1ns
module upfc_detect_timer #(
    parameter int CYCLES = upfc_pkg::DETECT_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // control
    input  wire logic start_i,
    output logic      done_o
);
    logic [7:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_q <= 8'h00;
        end else if (start_i) begin
            cnt_q <= 8'(CYCLES);
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    assign done_o = (cnt_q == 8'h01);
endmodule

// >>> logic/upfc_top.sv
// upstream port failover control with wishbone register slave
// Operation
// - failover off after reset unless failover boot mode sampled at fundamental reset
// - four boot modes enable failover: normal or eeprom, port 0 or 2
// - stack 0 always upstream; mux picks port 0 or 2 lanes in failover
// - in failover modes port 2 disabled downstream; ports 1, 3 normal
// - upstream side resources like status leds stay on port 0
// - dynamic failover forces detect, dl_down, flushes replay and queued data
// - after detect, flip lane mux to new port then start training
// - disable-linkdown-hot-reset bit suppresses hot reset on failover link down
// - failover enabled status bit reads set in failover modes
// - current upstream port status field readable in every mode
// - every dynamic failover sets sticky change bit kept over hot reset
// - hot reset leaves failover alone; controls inert outside failover mode
// - normal and port-0 failover modes start on port 0; port-2 modes port 2
// - same-type request during failover is dropped
// - other-type request during failover held and run afterwards; a pin request only if it comes during training
// - write changing software select field starts failover in failover mode
// - pin failover needs enable bit, failover mode, and differing port
// - port select input always follows general purpose pin 4
// - select pin low chooses port 0, high chooses port 2
`timescale 1ns/1ns
module upfc_top (
    // clock and fundamental reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    // boot straps and hot reset
    input  wire logic [3:0]             boot_switch_mode_i,
    input  wire logic                   hot_reset_i,
    // general purpose pin 4, the select pin
    input  wire logic                   gpio4_i,
    // link layer status
    input  wire logic                   link_up_i,
    // wishbone slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [3:0]             adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic [31:0]                 dat_o,
    output logic                        ack_o,
    // lane mux and port control
    output logic                        lane_sel_p2_o,
    output logic                        port2_disable_o,
    output logic                        led_port0_o,
    output upfc_pkg::upfc_link_s        link_ctrl_o,
    output logic                        hot_reset_req_o
);
    logic        fo_mode_d;
    logic        init_p2_d;
    logic        fo_mode_q;
    logic        current_upstream_port_q;
    logic        target_q;
    logic        sw_sel_q;
    logic        signal_failover_enable_q;
    logic        dldhr_q;
    logic        chg_q;
    logic        strap_done_q;
    logic        busy_type_q;
    logic        pend_q;
    logic        pend_port_q;
    logic        det_start;
    logic        det_done;
    logic        wr_stb;
    logic        rd_stb;
    logic        sw_req;
    logic        pin_req;
    upfc_pkg::upfc_req_s req;
    upfc_pkg::upfc_state_e state_q;

    upfc_mode_dec u_dec (
        .mode_i     (boot_switch_mode_i),
        .fo_mode_o  (fo_mode_d),
        .init_p2_o  (init_p2_d)
    );

    upfc_detect_timer #(
        .CYCLES (upfc_pkg::DETECT_CYC)
    ) u_tmr (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .start_i (det_start),
        .done_o  (det_done)
    );

    // bus strobes, one ack per request
    assign wr_stb = cyc_i && stb_i && !ack_o && we_i;
    assign rd_stb = cyc_i && stb_i && !ack_o && !we_i;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    // strap capture after fundamental reset release; hot reset has no effect
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            strap_done_q <= 1'b0;
            fo_mode_q    <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            fo_mode_q    <= fo_mode_d;
        end
    end

    // software control registers, kept across hot reset
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sw_sel_q <= 1'b0;
            signal_failover_enable_q <= 1'b0;
            dldhr_q  <= 1'b0;
        end else if (!strap_done_q) begin
            sw_sel_q <= init_p2_d;
        end else if (wr_stb && sel_i[0]) begin
            if (adr_i == upfc_pkg::ADDR_CTRL) begin
                sw_sel_q <= dat_i[upfc_pkg::CTRL_SEL_BIT];
                signal_failover_enable_q <= dat_i[upfc_pkg::CTRL_SIGNAL_FAILOVER_ENABLE_BIT];
            end else if (adr_i == upfc_pkg::ADDR_SWITCH_CONTROL_REG) begin
                dldhr_q  <= dat_i[upfc_pkg::SWITCH_CONTROL_REG_DLDHR_BIT];
            end
        end
    end

    // request sources
    assign sw_req  = fo_mode_q && wr_stb && sel_i[0] && (adr_i == upfc_pkg::ADDR_CTRL)
                   && (dat_i[upfc_pkg::CTRL_SEL_BIT] != sw_sel_q);
    assign pin_req = fo_mode_q && signal_failover_enable_q && (gpio4_i != current_upstream_port_q);
    assign req.sw  = sw_req;
    assign req.pin = pin_req;

    assign det_start = (state_q == upfc_pkg::UPFC_IDLE) && (req.sw || req.pin || pend_q);

    // failover sequencer
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_q     <= upfc_pkg::UPFC_IDLE;
            current_upstream_port_q      <= 1'b0;
            target_q    <= 1'b0;
            busy_type_q <= 1'b0;
            pend_q      <= 1'b0;
            pend_port_q <= 1'b0;
            chg_q       <= 1'b0;
        end else if (!strap_done_q) begin
            current_upstream_port_q   <= init_p2_d;
            target_q <= init_p2_d;
        end else begin
            case (state_q)
                upfc_pkg::UPFC_IDLE: begin
                    if (pend_q) begin
                        pend_q   <= 1'b0;
                        target_q <= pend_port_q;
                        state_q  <= upfc_pkg::UPFC_DOWN;
                    end else if (req.sw) begin
                        target_q    <= dat_i[upfc_pkg::CTRL_SEL_BIT];
                        busy_type_q <= 1'b0;
                        state_q     <= upfc_pkg::UPFC_DOWN;
                    end else if (req.pin) begin
                        target_q    <= gpio4_i;
                        busy_type_q <= 1'b1;
                        state_q     <= upfc_pkg::UPFC_DOWN;
                    end
                end
                upfc_pkg::UPFC_DOWN: begin
                    if (det_done) begin
                        state_q <= upfc_pkg::UPFC_SWITCH;
                    end
                end
                upfc_pkg::UPFC_SWITCH: begin
                    current_upstream_port_q  <= target_q;
                    chg_q   <= 1'b1;
                    state_q <= upfc_pkg::UPFC_TRAIN;
                end
                upfc_pkg::UPFC_TRAIN: begin
                    if (link_up_i) begin
                        state_q <= upfc_pkg::UPFC_IDLE;
                    end
                end
                default: begin
                    state_q <= upfc_pkg::UPFC_IDLE;
                end
            endcase
            // software request held in any busy state, pin request only in training; same-type dropped
            if (state_q != upfc_pkg::UPFC_IDLE && !pend_q) begin
                if (req.sw && busy_type_q) begin
                    pend_q      <= 1'b1;
                    pend_port_q <= dat_i[upfc_pkg::CTRL_SEL_BIT];
                    busy_type_q <= 1'b0;
                end else if (req.pin && !busy_type_q && state_q == upfc_pkg::UPFC_TRAIN) begin
                    pend_q      <= 1'b1;
                    pend_port_q <= gpio4_i;
                    busy_type_q <= 1'b1;
                end
            end
            if (rd_stb && adr_i == upfc_pkg::ADDR_STATUS && state_q != upfc_pkg::UPFC_SWITCH) begin
                chg_q <= 1'b0; // read clears; set wins in switch state
            end
        end
    end

    // link and port outputs
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            lane_sel_p2_o   <= 1'b0;
            port2_disable_o <= 1'b0;
            led_port0_o     <= 1'b0;
            link_ctrl_o     <= '0;
            hot_reset_req_o <= 1'b0;
        end else begin
            lane_sel_p2_o   <= fo_mode_q && current_upstream_port_q;
            port2_disable_o <= fo_mode_q;
            led_port0_o     <= link_up_i;
            link_ctrl_o.force_detect <= (state_q == upfc_pkg::UPFC_DOWN);
            link_ctrl_o.dl_down      <= (state_q == upfc_pkg::UPFC_DOWN);
            link_ctrl_o.flush        <= (state_q == upfc_pkg::UPFC_DOWN);
            link_ctrl_o.start_train  <= (state_q == upfc_pkg::UPFC_TRAIN);
            hot_reset_req_o <= hot_reset_i
                || ((state_q == upfc_pkg::UPFC_DOWN) && !dldhr_q);
        end
    end

    // read data
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_stb) begin
            dat_o <= 32'h0000_0000;
            case (adr_i)
                upfc_pkg::ADDR_CTRL: begin
                    dat_o[upfc_pkg::CTRL_SEL_BIT]    <= sw_sel_q;
                    dat_o[upfc_pkg::CTRL_SIGNAL_FAILOVER_ENABLE_BIT] <= signal_failover_enable_q;
                end
                upfc_pkg::ADDR_STATUS: begin
                    dat_o[upfc_pkg::STS_EN_BIT]   <= fo_mode_q;
                    dat_o[upfc_pkg::STS_CURRENT_UPSTREAM_PORT_BIT] <= current_upstream_port_q;
                    dat_o[upfc_pkg::STS_CHG_BIT]  <= chg_q;
                    dat_o[upfc_pkg::STS_CHGI_BIT] <= (state_q != upfc_pkg::UPFC_IDLE);
                end
                upfc_pkg::ADDR_SWITCH_CONTROL_REG: begin
                    dat_o[upfc_pkg::SWITCH_CONTROL_REG_DLDHR_BIT] <= dldhr_q;
                end
                default: begin
                    dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule

// >>> sim/upfc_rc_model.sv
// far-end link partner model that trains the upstream link
`timescale 1ns/1ns
module upfc_rc_model (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // link control and training delay
    input  wire upfc_pkg::upfc_link_s link_ctrl_i,
    input  wire logic [4:0]           dly_i,
    // trained link
    output logic                      link_up_o
);
    logic [4:0] cnt_q;
    logic       fo_q;
    // trains alone after boot, later only on start_train
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || link_ctrl_i.force_detect || link_ctrl_i.dl_down) begin
            cnt_q     <= 5'h00;
            link_up_o <= 1'b0;
        end else if ((link_ctrl_i.start_train || !fo_q) && !link_up_o) begin
            cnt_q     <= cnt_q + 5'h01;
            link_up_o <= (cnt_q >= dly_i);
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) fo_q <= 1'b0;
        else if (link_ctrl_i.force_detect) fo_q <= 1'b1;
    end
endmodule

// >>> sim/upfc_top_asserts.sv
// port checker for the failover control block
`timescale 1ns/1ns
module upfc_top_chk (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // watched ports
    input  wire logic                 link_up_i,
    input  wire logic                 ack_o,
    input  wire logic                 lane_sel_p2_o,
    input  wire logic                 port2_disable_o,
    input  wire logic                 led_port0_o,
    input  wire upfc_pkg::upfc_link_s link_ctrl_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    chk_led_follow: assert property ($past(rst_b_i) |->
        led_port0_o == $past(link_up_i)) else $error("led does not follow link");
    chk_lane_static: assert property (!port2_disable_o |-> !lane_sel_p2_o)
        else $error("port 2 lanes chosen outside failover");
    chk_down_flush: assert property ($rose(link_ctrl_o.force_detect) |->
        link_ctrl_o.dl_down && link_ctrl_o.flush) else $error("detect without flush");
    chk_down_hold: assert property ($rose(link_ctrl_o.force_detect) |->
        link_ctrl_o.force_detect[*7]) else $error("detect hold too short");
    chk_mux_after_down: assert property ($changed(lane_sel_p2_o) && $past(port2_disable_o) |->
        $past(link_ctrl_o.force_detect, 2)) else $error("mux moved outside detect");
    chk_train_bound: assert property ($rose(link_ctrl_o.force_detect) |->
        ##[7:12] link_ctrl_o.start_train) else $error("training not started");
    chk_inert_normal: assert property (!port2_disable_o |-> link_ctrl_o == 4'h0)
        else $error("link control active outside failover");
    cover property ($rose(link_ctrl_o.force_detect));
    cover property ($rose(lane_sel_p2_o));
    cover property ($fell(lane_sel_p2_o));
endmodule
bind upfc_top upfc_top_chk u_upfc_top_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .link_up_i(link_up_i), .ack_o(ack_o), .lane_sel_p2_o(lane_sel_p2_o),
    .port2_disable_o(port2_disable_o), .led_port0_o(led_port0_o), .link_ctrl_o(link_ctrl_o));

// >>> sim/tb.sv
// self-checking testbench for the failover control block
`timescale 1ns/1ns
module tb;
    localparam logic [3:0] CTL = upfc_pkg::ADDR_CTRL;
    localparam logic [3:0] STS = upfc_pkg::ADDR_STATUS;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [3:0]  mode = 4'h0;
    logic        hot_reset_i = 1'b0;
    logic        gpio4_i = 1'b0;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [4:0]  dly = 5'h02;
    logic [31:0] dat_o;
    logic        ack_o, lane, p2dis, hrq, link_up, fd_q;
    logic        hr_seen = 1'b0;
    logic [31:0] exp_q[$];
    int          failures = 0;
    int          n_checks = 0;
    int          n_fo = 0;
    int          seed = 32'ha2abbc1a;
    upfc_pkg::upfc_link_s lc;
    always #4 clk_i = ~clk_i;
    upfc_top u_upfc_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .boot_switch_mode_i(mode),
        .hot_reset_i(hot_reset_i), .gpio4_i(gpio4_i), .link_up_i(link_up), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .lane_sel_p2_o(lane), .port2_disable_o(p2dis),
        .led_port0_o(), .link_ctrl_o(lc), .hot_reset_req_o(hrq));
    upfc_rc_model u_upfc_rc_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .link_ctrl_i(lc),
        .dly_i(dly), .link_up_o(link_up));
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, ($random(seed) & 32'hffff_ff00) | d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 300 && (lc !== 4'h0 || link_up !== 1'b1); i++) @(posedge clk_i);
    endtask
    task automatic boot(input logic [3:0] m);
        rst_b_i <= 1'b0;
        mode    <= m;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        settle();
    endtask
    // read data checked against the oldest note
    always @(posedge clk_i) begin
        fd_q <= lc.force_detect;
        if (lc.force_detect === 1'b1 && fd_q === 1'b0) n_fo++;
        if (hrq === 1'b1) hr_seen = 1'b1;
        if (ack_o === 1'b1 && we_i === 1'b0) cmp("read data", exp_q.pop_front(), dat_o);
    end
    initial begin
        for (int m = 0; m < 6; m++) begin
            boot(m[3:0]);
            cmp("port2 disable", m > 1, p2dis);
            cmp("lane select", m == 3 || m == 5, lane);
            rd(STS, {30'h0, m == 3 || m == 5, m > 1});
        end
        boot(upfc_pkg::MODE_NORMAL);
        gpio4_i <= 1'($random(seed));
        wr(CTL, 32'h3);
        wr(4'hc, 32'h0);
        rd(4'hc, 32'h0);
        settle();
        cmp("failovers", 0, n_fo);
        gpio4_i <= 1'b0;
        boot(upfc_pkg::MODE_FO_P0);
        hr_seen = 1'b0;
        wr(CTL, 32'h1);
        settle();
        cmp("hot reset req", 1, hr_seen);
        hot_reset_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        hot_reset_i <= 1'b0;
        @(posedge clk_i);
        rd(STS, 32'h7);
        rd(STS, 32'h3);
        cmp("lane select", 1, lane);
        n_fo = 0;
        wr(CTL, 32'h0);
        wr(CTL, 32'h1);
        settle();
        cmp("lane select", 0, lane);
        cmp("failovers", 1, n_fo);
        dly <= 5'h14;
        wr(upfc_pkg::ADDR_SWITCH_CONTROL_REG, 32'h1);
        hr_seen = 1'b0;
        n_fo = 0;
        gpio4_i <= 1'b1;
        wr(CTL, 32'h3);
        wr(CTL, 32'h0);
        settle();
        settle();
        cmp("failovers", 2, n_fo);
        cmp("lane select", 0, lane);
        cmp("hot reset req", 0, hr_seen);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        final_report();
    end
endmodule
